// *** hdl/io_space_pkg.sv ***
package io_space_pkg;

    // operations the core issues towards the register space
    typedef enum logic [2:0] {
        in_port_op,
        out_port_op,
        direct_load_op,
        direct_store_op,
        set_single_bit_op,
        clear_single_bit_op,
        skip_if_bit_set_op,
        skip_if_bit_clear_op
    } io_op_t;

    // address views
    localparam logic [8:0] IO_DATA_OFFSET = 9'h020;
    localparam logic [8:0] IO_PORT_LAST = 9'h03F;
    localparam logic [8:0] IO_BIT_LAST = 9'h01F;
    localparam logic [8:0] EXT_FIRST = 9'h060;
    localparam logic [8:0] EXT_LAST = 9'h1FF;

    // short i/o addresses of the mapped registers
    localparam logic [5:0] PORT_B_INPUT_PINS = 6'h03;
    localparam logic [5:0] PORT_B_DIRECTION = 6'h04;
    localparam logic [5:0] PORT_B_OUTPUT = 6'h05;
    localparam logic [5:0] PORT_C_INPUT_PINS = 6'h06;
    localparam logic [5:0] PORT_C_DIRECTION = 6'h07;
    localparam logic [5:0] PORT_C_OUTPUT = 6'h08;
    localparam logic [5:0] PORT_D_INPUT_PINS = 6'h09;
    localparam logic [5:0] PORT_D_DIRECTION = 6'h0A;
    localparam logic [5:0] PORT_D_OUTPUT = 6'h0B;
    localparam logic [5:0] TIMER0_FLAGS = 6'h15;
    localparam logic [5:0] TIMER1_FLAGS = 6'h16;
    localparam logic [5:0] GENERAL_SCRATCH_0 = 6'h1E;
    localparam logic [5:0] NVM_CONTROL = 6'h1F;
    localparam logic [5:0] NVM_DATA = 6'h20;
    localparam logic [5:0] NVM_ADDRESS_LOW = 6'h21;
    localparam logic [5:0] NVM_ADDRESS_HIGH = 6'h22;
    localparam logic [5:0] TIMER_SYNC_CONTROL = 6'h23;
    localparam logic [5:0] TIMER0_CONTROL_A = 6'h24;
    localparam logic [5:0] TIMER0_CONTROL_B = 6'h25;
    localparam logic [5:0] TIMER0_COUNT = 6'h26;
    localparam logic [5:0] TIMER0_COMPARE_A = 6'h27;
    localparam logic [5:0] TIMER0_COMPARE_B = 6'h28;
    localparam logic [5:0] PLL_CONTROL_STATUS = 6'h29;
    localparam logic [5:0] GENERAL_SCRATCH_1 = 6'h2A;
    localparam logic [5:0] GENERAL_SCRATCH_2 = 6'h2B;
    localparam logic [5:0] SERIAL_PERIPH_CONTROL = 6'h2C;
    localparam logic [5:0] SERIAL_PERIPH_STATUS = 6'h2D;
    localparam logic [5:0] SERIAL_PERIPH_DATA = 6'h2E;
    localparam logic [5:0] COMPARATOR_CONTROL_STATUS = 6'h30;
    localparam logic [5:0] DEBUG_LINK_DATA = 6'h31;
    // data-space address of the mask in the extended region
    localparam logic [8:0] EXTERNAL_IRQ_MASK = 9'h067;

    // flag bits that exist in the two timer flag registers
    localparam logic [7:0] TIMER0_FLAG_BITS = 8'h07;
    localparam logic [7:0] TIMER1_FLAG_BITS = 8'h2F;
    localparam logic [7:0] REG_RESET = 8'h00;

    // controller registers on the wishbone side (byte addresses)
    localparam logic [4:0] CMD_ADDR = 5'h00;
    localparam logic [4:0] TARGET_ADDR = 5'h04;
    localparam logic [4:0] WDATA_ADDR = 5'h08;
    localparam logic [4:0] STATUS_ADDR = 5'h0C;
    localparam logic [4:0] IRQ_STATUS_ADDR = 5'h10;
    localparam logic [4:0] IRQ_MASK_ADDR = 5'h14;
    // command field positions
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BIT_LSB = 4;
    // status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_RDATA_LSB = 8;
    // interrupt event bits
    localparam int EV_DONE = 0;
    localparam int EV_REFUSED = 1;

endpackage : io_space_pkg

// *** hdl/io_bus_if.sv ***
`timescale 1ns/1ps
interface io_bus_if;
    logic req;
    io_space_pkg::io_op_t op;
    logic [8:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic skip;
    logic refused;

    modport core (output req, output op, output addr, output bit_sel, output wdata,
                  input ack, input rdata, input skip, input refused);
    modport dev (input req, input op, input addr, input bit_sel, input wdata,
                 output ack, output rdata, output skip, output refused);
endinterface : io_bus_if

// *** hdl/io_register_space_decoder.sv ***
// Summary of operation
// - port ops use i/o address; load/store add 0x20
// - port ops reach only 64 locations
// - extended 0x60..0x1FF only by load/store
// - bit set/clear on i/o 0x00..0x1F
// - bit skip test on i/o 0x00..0x1F
// - flags clear on written one, zero keeps
// - bit set/clear is whole-register read-modify-write
// - software writes zero to reserved bits
// - software never writes reserved addresses
`timescale 1ns/1ps
module io_register_space_decoder (
    input wire logic clk,
    input wire logic nrst,
    io_bus_if.dev bus,
    input wire logic [7:0] port_b_pins,
    input wire logic [7:0] port_c_pins,
    input wire logic [7:0] port_d_pins,
    input wire logic [7:0] timer0_events,
    input wire logic [7:0] timer1_events,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_b_output,
    output logic [7:0] port_c_direction,
    output logic [7:0] port_c_output,
    output logic [7:0] port_d_direction,
    output logic [7:0] port_d_output,
    output logic [7:0] external_irq_mask
);

    logic [7:0] io_mem [0:63];
    logic [7:0] timer0_flags_reg;
    logic [7:0] timer1_flags_reg;
    logic [7:0] ext_mask_reg;
    logic [7:0] pin_meta_reg [0:2];
    logic [7:0] pin_sync_reg [0:2];
    logic ack_reg;
    logic [7:0] rdata_reg;
    logic skip_reg;
    logic refused_reg;

    // decode results
    logic legal;
    logic io_hit;
    logic ext_hit;
    logic [5:0] io_sel;
    logic is_write;
    logic is_bit_op;
    logic [7:0] cur_val;
    logic [7:0] wr_val;
    logic [8:0] data_addr;

    // true for short addresses that hold a stored read/write register
    function automatic logic stored_reg(input logic [5:0] a);
        case (a)
            io_space_pkg::PORT_B_DIRECTION, io_space_pkg::PORT_B_OUTPUT,
            io_space_pkg::PORT_C_DIRECTION, io_space_pkg::PORT_C_OUTPUT,
            io_space_pkg::PORT_D_DIRECTION, io_space_pkg::PORT_D_OUTPUT,
            io_space_pkg::GENERAL_SCRATCH_0, io_space_pkg::NVM_CONTROL,
            io_space_pkg::NVM_DATA, io_space_pkg::NVM_ADDRESS_LOW,
            io_space_pkg::NVM_ADDRESS_HIGH, io_space_pkg::TIMER_SYNC_CONTROL,
            io_space_pkg::TIMER0_CONTROL_A, io_space_pkg::TIMER0_CONTROL_B,
            io_space_pkg::TIMER0_COUNT, io_space_pkg::TIMER0_COMPARE_A,
            io_space_pkg::TIMER0_COMPARE_B, io_space_pkg::PLL_CONTROL_STATUS,
            io_space_pkg::GENERAL_SCRATCH_1, io_space_pkg::GENERAL_SCRATCH_2,
            io_space_pkg::SERIAL_PERIPH_CONTROL, io_space_pkg::SERIAL_PERIPH_STATUS,
            io_space_pkg::SERIAL_PERIPH_DATA, io_space_pkg::COMPARATOR_CONTROL_STATUS,
            io_space_pkg::DEBUG_LINK_DATA: stored_reg = 1'b1;
            default: stored_reg = 1'b0;
        endcase
    endfunction : stored_reg

    // pin levels come from outside the clock domain: two stages before use
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 3; i++) begin
                pin_meta_reg[i] <= io_space_pkg::REG_RESET;
                pin_sync_reg[i] <= io_space_pkg::REG_RESET;
            end
        end else begin
            pin_meta_reg[0] <= port_b_pins;
            pin_meta_reg[1] <= port_c_pins;
            pin_meta_reg[2] <= port_d_pins;
            for (int i = 0; i < 3; i++) begin
                pin_sync_reg[i] <= pin_meta_reg[i];
            end
        end
    end

    // map the request onto one short address or the extended region
    always_comb begin
        legal = 1'b0;
        io_hit = 1'b0;
        ext_hit = 1'b0;
        io_sel = bus.addr[5:0];
        data_addr = bus.addr;
        is_write = 1'b0;
        is_bit_op = 1'b0;
        case (bus.op)
            io_space_pkg::in_port_op, io_space_pkg::out_port_op: begin
                legal = (bus.addr <= io_space_pkg::IO_PORT_LAST);
                io_hit = legal;
                is_write = (bus.op == io_space_pkg::out_port_op);
            end
            io_space_pkg::set_single_bit_op, io_space_pkg::clear_single_bit_op: begin
                legal = (bus.addr <= io_space_pkg::IO_BIT_LAST);
                io_hit = legal;
                is_write = 1'b1;
                is_bit_op = 1'b1;
            end
            io_space_pkg::skip_if_bit_set_op, io_space_pkg::skip_if_bit_clear_op: begin
                legal = (bus.addr <= io_space_pkg::IO_BIT_LAST);
                io_hit = legal;
            end
            io_space_pkg::direct_load_op, io_space_pkg::direct_store_op: begin
                legal = (bus.addr >= io_space_pkg::IO_DATA_OFFSET);
                data_addr = bus.addr - io_space_pkg::IO_DATA_OFFSET;
                io_hit = legal && (bus.addr < io_space_pkg::EXT_FIRST);
                ext_hit = legal && (bus.addr >= io_space_pkg::EXT_FIRST);
                io_sel = io_hit ? data_addr[5:0] : bus.addr[5:0];
                is_write = (bus.op == io_space_pkg::direct_store_op);
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

    // current content of the selected location; reserved ones read as zero
    always_comb begin
        cur_val = io_space_pkg::REG_RESET;
        if (io_hit) begin
            case (io_sel)
                io_space_pkg::PORT_B_INPUT_PINS: cur_val = pin_sync_reg[0];
                io_space_pkg::PORT_C_INPUT_PINS: cur_val = pin_sync_reg[1];
                io_space_pkg::PORT_D_INPUT_PINS: cur_val = pin_sync_reg[2];
                io_space_pkg::TIMER0_FLAGS: cur_val = timer0_flags_reg;
                io_space_pkg::TIMER1_FLAGS: cur_val = timer1_flags_reg;
                default: cur_val = stored_reg(io_sel) ? io_mem[io_sel] : 8'h00;
            endcase
        end else if (ext_hit && bus.addr == io_space_pkg::EXTERNAL_IRQ_MASK) begin
            cur_val = ext_mask_reg;
        end
    end

    // bit ops write back the whole register, so every flag that reads as set, except the one a clear op selects, is written as one and cleared
    always_comb begin
        case (bus.op)
            io_space_pkg::set_single_bit_op:
                wr_val = cur_val | (8'h01 << bus.bit_sel);
            io_space_pkg::clear_single_bit_op:
                wr_val = cur_val & ~(8'h01 << bus.bit_sel);
            default: wr_val = bus.wdata;
        endcase
    end

    // stored registers; pin registers ignore writes, reserved ones too
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 64; i++) begin
                io_mem[i] <= io_space_pkg::REG_RESET;
            end
        end else if (bus.req && legal && is_write && io_hit && stored_reg(io_sel)) begin
            io_mem[io_sel] <= wr_val;
        end
    end

    // extended-region mask, reachable only by load/store
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_mask_reg <= io_space_pkg::REG_RESET;
        end else if (bus.req && legal && is_write && ext_hit
                     && bus.addr == io_space_pkg::EXTERNAL_IRQ_MASK) begin
            ext_mask_reg <= wr_val;
        end
    end

    // timer flags: a one written clears, a new event in the same cycle wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer0_flags_reg <= io_space_pkg::REG_RESET;
            timer1_flags_reg <= io_space_pkg::REG_RESET;
        end else begin
            if (bus.req && legal && is_write && io_hit && io_sel == io_space_pkg::TIMER0_FLAGS) begin
                timer0_flags_reg <= (timer0_flags_reg & ~wr_val
                                     | timer0_events) & io_space_pkg::TIMER0_FLAG_BITS;
            end else begin
                timer0_flags_reg <= (timer0_flags_reg | timer0_events)
                                    & io_space_pkg::TIMER0_FLAG_BITS;
            end
            if (bus.req && legal && is_write && io_hit && io_sel == io_space_pkg::TIMER1_FLAGS) begin
                timer1_flags_reg <= (timer1_flags_reg & ~wr_val
                                     | timer1_events) & io_space_pkg::TIMER1_FLAG_BITS;
            end else begin
                timer1_flags_reg <= (timer1_flags_reg | timer1_events)
                                    & io_space_pkg::TIMER1_FLAG_BITS;
            end
        end
    end

    // answer one cycle after the request; reads have no side effect
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            rdata_reg <= io_space_pkg::REG_RESET;
            skip_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            ack_reg <= bus.req;
            if (bus.req) begin
                rdata_reg <= legal ? cur_val : 8'h00;
                refused_reg <= !legal;
                case (bus.op)
                    io_space_pkg::skip_if_bit_set_op:
                        skip_reg <= legal && cur_val[bus.bit_sel];
                    io_space_pkg::skip_if_bit_clear_op:
                        skip_reg <= legal && !cur_val[bus.bit_sel];
                    default: skip_reg <= 1'b0;
                endcase
            end
        end
    end

    assign bus.ack = ack_reg;
    assign bus.rdata = rdata_reg;
    assign bus.skip = skip_reg;
    assign bus.refused = refused_reg;

    // port registers drive the pins directly from their flops
    assign port_b_direction = io_mem[io_space_pkg::PORT_B_DIRECTION];
    assign port_b_output = io_mem[io_space_pkg::PORT_B_OUTPUT];
    assign port_c_direction = io_mem[io_space_pkg::PORT_C_DIRECTION];
    assign port_c_output = io_mem[io_space_pkg::PORT_C_OUTPUT];
    assign port_d_direction = io_mem[io_space_pkg::PORT_D_DIRECTION];
    assign port_d_output = io_mem[io_space_pkg::PORT_D_OUTPUT];
    assign external_irq_mask = ext_mask_reg;

endmodule : io_register_space_decoder

// *** hdl/io_core_port.sv ***
`timescale 1ns/1ps
module io_core_port (
    input wire logic clk,
    input wire logic nrst,
    io_bus_if.core bus,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);

    typedef enum logic [1:0] {idle_s, issue_s, wait_s} core_state_t;

    core_state_t state_reg;
    logic req_reg;
    io_space_pkg::io_op_t op_reg;
    logic [2:0] bit_reg;
    logic [8:0] target_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic skip_reg;
    logic refused_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    logic [31:0] dat_o_reg;
    logic ack_reg;
    logic irq_reg;
    logic wb_go;
    logic wr_go;
    logic [31:0] rd_mux;
    logic [1:0] ev_next;

    // one-cycle access; the ack clears itself so each access answers once
    assign wb_go = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_go = wb_go && wb_we_i && wb_sel_i[0];

    always_comb begin
        case (wb_adr_i)
            io_space_pkg::CMD_ADDR: rd_mux = {24'h000000, 1'b0, bit_reg, 1'b0, op_reg};
            io_space_pkg::TARGET_ADDR: rd_mux = {23'h000000, target_reg};
            io_space_pkg::WDATA_ADDR: rd_mux = {24'h000000, wdata_reg};
            io_space_pkg::STATUS_ADDR: rd_mux = {16'h0000, rdata_reg, 5'h00, refused_reg,
                                                 skip_reg, state_reg != idle_s};
            io_space_pkg::IRQ_STATUS_ADDR: rd_mux = {30'h00000000, irq_status_reg};
            io_space_pkg::IRQ_MASK_ADDR: rd_mux = {30'h00000000, irq_mask_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // bus answer registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            dat_o_reg <= 32'h00000000;
        end else begin
            ack_reg <= wb_go;
            if (wb_go && !wb_we_i) begin
                dat_o_reg <= rd_mux;
            end
        end
    end

    // target and write data; the target's bit 8 lives in byte lane 1
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            target_reg <= 9'h000;
            wdata_reg <= 8'h00;
        end else if (wb_go && wb_we_i) begin
            if (wb_adr_i == io_space_pkg::TARGET_ADDR) begin
                if (wb_sel_i[0]) target_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) target_reg[8] <= wb_dat_i[8];
            end
            if (wr_go && wb_adr_i == io_space_pkg::WDATA_ADDR) begin
                wdata_reg <= wb_dat_i[7:0];
            end
        end
    end

    // command launch: a write to the command register while idle starts an access,
    // a write while busy is dropped so the core never sees overlapping requests
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= idle_s;
            req_reg <= 1'b0;
            op_reg <= io_space_pkg::in_port_op;
            bit_reg <= 3'h0;
            rdata_reg <= 8'h00;
            skip_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            case (state_reg)
                idle_s: begin
                    if (wr_go && wb_adr_i == io_space_pkg::CMD_ADDR) begin
                        op_reg <= io_space_pkg::io_op_t'(wb_dat_i[io_space_pkg::CMD_OP_LSB +: 3]);
                        bit_reg <= wb_dat_i[io_space_pkg::CMD_BIT_LSB +: 3];
                        req_reg <= 1'b1;
                        state_reg <= issue_s;
                    end
                end
                issue_s: begin
                    req_reg <= 1'b0;
                    state_reg <= wait_s;
                end
                wait_s: begin
                    if (bus.ack) begin
                        rdata_reg <= bus.rdata;
                        skip_reg <= bus.skip;
                        refused_reg <= bus.refused;
                        state_reg <= idle_s;
                    end
                end
                default: begin
                    req_reg <= 1'b0;
                    state_reg <= idle_s;
                end
            endcase
        end
    end

    // sticky events, write one to clear; an event in the clearing cycle survives
    always_comb begin
        ev_next = 2'b00;
        ev_next[io_space_pkg::EV_DONE] = (state_reg == wait_s) && bus.ack;
        ev_next[io_space_pkg::EV_REFUSED] = (state_reg == wait_s) && bus.ack && bus.refused;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_status_reg <= 2'b00;
            irq_mask_reg <= 2'b00;
            irq_reg <= 1'b0;
        end else begin
            if (wr_go && wb_adr_i == io_space_pkg::IRQ_STATUS_ADDR) begin
                irq_status_reg <= (irq_status_reg & ~wb_dat_i[1:0]) | ev_next;
            end else begin
                irq_status_reg <= irq_status_reg | ev_next;
            end
            if (wr_go && wb_adr_i == io_space_pkg::IRQ_MASK_ADDR) begin
                irq_mask_reg <= wb_dat_i[1:0];
            end
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    assign bus.req = req_reg;
    assign bus.op = op_reg;
    assign bus.addr = target_reg;
    assign bus.bit_sel = bit_reg;
    assign bus.wdata = wdata_reg;
    assign wb_dat_o = dat_o_reg;
    assign wb_ack_o = ack_reg;
    assign irq_o = irq_reg;

endmodule : io_core_port

// *** verif/io_space_monitor.sv ***
`timescale 1ns/1ps
module io_space_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req,
    input io_space_pkg::io_op_t op,
    input wire logic [8:0] addr,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic skip,
    input wire logic refused
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // request classes: each view has its own reach
    wire is_port = op == io_space_pkg::in_port_op || op == io_space_pkg::out_port_op;
    wire is_mem = op == io_space_pkg::direct_load_op || op == io_space_pkg::direct_store_op;
    wire is_bit = !is_port && !is_mem;
    wire is_gap = addr < 9'h003 || (addr > 9'h00B && addr < 9'h015);

    chk_ack_follows: assert property (req |=> ack)
        else $error("no answer after request");
    chk_ack_cause: assert property (ack |-> $past(req))
        else $error("answer without request");
    chk_one_pending: assert property (req |=> !req [*2])
        else $error("request while one is pending");
    chk_port_reach: assert property (req && is_port |=> refused == ($past(addr) > 9'h03F))
        else $error("port op reach wrong");
    chk_bit_reach: assert property (req && is_bit |=> refused == ($past(addr) > 9'h01F))
        else $error("bit op reach wrong");
    chk_mem_reach: assert property (req && is_mem |=> refused == ($past(addr) < 9'h020))
        else $error("load or store reach wrong");
    chk_gap_reads: assert property (req && op == io_space_pkg::in_port_op && is_gap |=> rdata == 8'h00)
        else $error("reserved place read not zero");
    // answers must not drift between acknowledges
    chk_answer_holds: assert property (!ack |-> $stable(rdata) && $stable(skip) && $stable(refused))
        else $error("answer changed without ack");
endmodule : io_space_monitor

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] dat = 32'h00000000;
    logic [7:0] ev0 = 8'h00;
    logic [7:0] ev1 = 8'h00;
    logic [31:0] wbo, rd, st;
    logic ack, irq;
    logic [7:0] pb_dir, pb_out, pc_dir, pc_out, pd_dir, pd_out, xmask;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    io_bus_if bus_if ();

    always #50 clk = ~clk;

    io_register_space_decoder io_register_space_decoder_i (.clk(clk), .nrst(nrst), .bus(bus_if),
        .port_b_pins(8'h3C), .port_c_pins(8'h00), .port_d_pins(8'h96),
        .timer0_events(ev0), .timer1_events(ev1), .port_b_direction(pb_dir),
        .port_b_output(pb_out), .port_c_direction(pc_dir), .port_c_output(pc_out),
        .port_d_direction(pd_dir), .port_d_output(pd_out), .external_irq_mask(xmask));
    io_core_port io_core_port_i (.clk(clk), .nrst(nrst), .bus(bus_if), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wbo), .wb_ack_o(ack), .irq_o(irq));
    io_space_monitor io_space_monitor_i (.clk(clk), .nrst(nrst), .req(bus_if.req),
        .op(bus_if.op), .addr(bus_if.addr), .ack(bus_if.ack), .rdata(bus_if.rdata),
        .skip(bus_if.skip), .refused(bus_if.refused));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = wbo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // launch one core operation and poll until the controller is idle
    task automatic op_run(input io_space_pkg::io_op_t o, input logic [8:0] a,
                          input logic [2:0] b, input logic [7:0] d);
        wb(1'b1, io_space_pkg::TARGET_ADDR, {23'h000000, a});
        wb(1'b1, io_space_pkg::WDATA_ADDR, {24'h000000, d});
        wb(1'b1, io_space_pkg::CMD_ADDR, {25'h0000000, b, 1'b0, o});
        do begin
            wb(1'b0, io_space_pkg::STATUS_ADDR, 32'h00000000);
        end while (rd[0] !== 1'b0);
        st = rd & 32'h0000FF07;
    endtask : op_run

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        op_run(io_space_pkg::out_port_op, 9'h005, 3'h0, 8'hA5);
        check("port b out", {24'h0, pb_out}, 32'h000000A5);
        op_run(io_space_pkg::direct_load_op, 9'h025, 3'h0, 8'h00);
        check("load of port b out", st & 32'hFF05, 32'h0000A500);
        op_run(io_space_pkg::direct_store_op, 9'h024, 3'h0, 8'h3C);
        op_run(io_space_pkg::in_port_op, 9'h004, 3'h0, 8'h00);
        check("port b dir", st & 32'hFF05, 32'h00003C00);
        check("port pins idle", {pb_dir, pc_dir, pc_out, pd_dir}, 32'h3C000000);
        op_run(io_space_pkg::direct_load_op, 9'h023, 3'h0, 8'h00);
        check("port b pins", st & 32'hFF05, 32'h00003C00);
        op_run(io_space_pkg::in_port_op, 9'h040, 3'h0, 8'h00);
        check("port op above window", st & 32'h4, 32'h4);
        op_run(io_space_pkg::direct_store_op, 9'h067, 3'h0, 8'h5A);
        check("extended mask", {24'h0, xmask}, 32'h0000005A);
        op_run(io_space_pkg::out_port_op, 9'h067, 3'h0, 8'h11);
        check("extended by port op", {24'h0, xmask} | (st & 32'h4), 32'h0000005E);
        op_run(io_space_pkg::direct_load_op, 9'h067, 3'h0, 8'h00);
        check("load of mask", st & 32'hFF05, 32'h00005A00);
        op_run(io_space_pkg::direct_load_op, 9'h01F, 3'h0, 8'h00);
        check("load below offset", st & 32'h4, 32'h4);
        op_run(io_space_pkg::set_single_bit_op, 9'h020, 3'h0, 8'h00);
        check("bit op above range", st & 32'h4, 32'h4);
        // bit set, clear and the two skip tests on one port register
        op_run(io_space_pkg::out_port_op, 9'h00B, 3'h0, 8'h81);
        op_run(io_space_pkg::set_single_bit_op, 9'h00B, 3'h3, 8'h00);
        check("bit set", {24'h0, pd_out}, 32'h00000089);
        op_run(io_space_pkg::clear_single_bit_op, 9'h00B, 3'h0, 8'h00);
        check("bit clear", {24'h0, pd_out}, 32'h00000088);
        op_run(io_space_pkg::skip_if_bit_set_op, 9'h00B, 3'h3, 8'h00);
        check("skip on set", st & 32'h6, 32'h2);
        op_run(io_space_pkg::skip_if_bit_clear_op, 9'h00B, 3'h3, 8'h00);
        check("no skip on clear", st & 32'h6, 32'h0);
        op_run(io_space_pkg::skip_if_bit_clear_op, 9'h00B, 3'h2, 8'h00);
        check("skip on clear", st & 32'h6, 32'h2);
        // flag events, then write-one-to-clear and the bit op side effect
        ev0 <= 8'hFF;
        ev1 <= 8'hFF;
        @(posedge clk);
        ev0 <= 8'h00;
        ev1 <= 8'h00;
        op_run(io_space_pkg::in_port_op, 9'h015, 3'h0, 8'h00);
        check("timer0 flags", st & 32'hFF05, 32'h00000700);
        op_run(io_space_pkg::out_port_op, 9'h015, 3'h0, 8'h01);
        op_run(io_space_pkg::out_port_op, 9'h015, 3'h0, 8'h00);
        op_run(io_space_pkg::in_port_op, 9'h015, 3'h0, 8'h00);
        check("flag clear by one", st & 32'hFF05, 32'h00000600);
        op_run(io_space_pkg::set_single_bit_op, 9'h016, 3'h7, 8'h00);
        op_run(io_space_pkg::in_port_op, 9'h016, 3'h0, 8'h00);
        check("flags cleared by bit set", st & 32'hFF05, 32'h00000000);
        op_run(io_space_pkg::in_port_op, 9'h000, 3'h0, 8'h00);
        check("reserved read", st & 32'hFF05, 32'h00000000);
        // interrupt: done masked out, refused unmasked, then cleared
        wb(1'b1, io_space_pkg::IRQ_STATUS_ADDR, 32'h00000003);
        wb(1'b1, io_space_pkg::IRQ_MASK_ADDR, 32'h00000002);
        op_run(io_space_pkg::in_port_op, 9'h009, 3'h0, 8'h00);
        check("port d pins", st & 32'hFF05, 32'h00009600);
        repeat (2) @(posedge clk);
        check("irq masked", {31'h0, irq}, 32'h0);
        op_run(io_space_pkg::in_port_op, 9'h040, 3'h0, 8'h00);
        repeat (2) @(posedge clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        wb(1'b0, io_space_pkg::IRQ_STATUS_ADDR, 32'h00000000);
        check("irq status", rd, 32'h00000003);
        wb(1'b1, io_space_pkg::IRQ_STATUS_ADDR, 32'h00000002);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wb(1'b0, 5'h18, 32'h00000000);
        check("unmapped read", rd, 32'h00000000);
        end_sim();
    end
endmodule : testbench
